// ===== logic/uep_uart_enable.sv
/*
 * Serial transmit core with power/enable sequencing, clock-stop hold,
 * base-clock enable synchronisers, transmit completion interrupt and an
 * Avalon-MM register slave. Assumes one 10 MHz clock; the clock-stop
 * input comes from the system clock controller on the same clock.
 */
// Notes on behaviour
// - With the clock running, transmission goes on as in normal operation.
// - While the clock supply is stopped every register holds its last value; the prescaler still clears when power is off.
// - While the clock supply is stopped the transmit pin keeps its last level.
// - After the clock resumes nothing is guaranteed until software reinitialises.
// - Enable bits are sampled by synchronisers on the selected baud base clock.
`timescale 1ns/1ns
module uep_uart_enable
   import uep_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic clk_stop_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic serial_tx_pin_out,
   output logic tx_done_irq_out,
   output logic irq_out
);

   typedef enum logic [2:0] {
      UEP_TX_IDLE = 3'b001,
      UEP_TX_SHIFT = 3'b010,
      UEP_TX_DONE = 3'b100
   } uep_tx_state_e;

   // Gated clock enable: everything but the prescaler's power-off clear holds while the supply is stopped
   logic run;
   assign run = ~clk_stop_in;

   logic uart_power_on_q;
   logic tx_enable_bit_q;
   logic rx_enable_bit_q;
   logic [BAUD_SEL_W-1:0] baud_sel_q;
   logic [BAUD_DIV_W-1:0] baud_div_q;
   logic [DATA_BITS-1:0] tx_shift_reg_q;
   logic tx_load_q;
   logic irq_stat_q;
   logic irq_en_q;
   logic ack_q;
   logic [31:0] rdata_q;

   logic wr_hit;
   logic rd_hit;
   logic bus_req;
   assign bus_req = avs_read_in | avs_write_in;
   // Writes land on the acknowledging edge; reads are fetched one edge early
   assign wr_hit = avs_write_in & ack_q & run;
   assign rd_hit = avs_read_in & ~ack_q & run;
   // One wait state; a stopped clock withholds the answer, even one already due
   assign avs_waitrequest_out = bus_req & (~ack_q | clk_stop_in);
   assign avs_readdata_out = rdata_q;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else if (run) begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // Baud base clock: power-of-two prescaler selected by baud_sel_q
   // Prescaler rests at zero while powered down, so ticks restart in phase
   logic [7:0] pre_cnt_q;
   logic base_tick;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in | ~uart_power_on_q) begin
         pre_cnt_q <= 8'h00;
      end else if (run) begin
         pre_cnt_q <= pre_cnt_q + 8'h01;
      end
   end
   always_comb begin
      if (baud_sel_q == 3'h0) begin
         base_tick = uart_power_on_q;
      end else begin
         base_tick = uart_power_on_q &
            (pre_cnt_q[baud_sel_q - 3'h1 -: 1] == 1'b1) &
            ((pre_cnt_q & ((8'h01 << baud_sel_q) - 8'h01)) == ((8'h01 << baud_sel_q) - 8'h01));
      end
   end

   // Enable synchronisers stepped by the base clock
   // Power-off empties the chain: the reinitialisation path after a stop
   logic [1:0] txe_sync_q;
   logic [1:0] rxe_sync_q;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         txe_sync_q <= 2'b00;
         rxe_sync_q <= 2'b00;
      end else if (run & base_tick) begin
         txe_sync_q <= {txe_sync_q[0], tx_enable_bit_q & uart_power_on_q};
         rxe_sync_q <= {rxe_sync_q[0], rx_enable_bit_q & uart_power_on_q};
      end else if (run & ~uart_power_on_q) begin
         txe_sync_q <= 2'b00;
         rxe_sync_q <= 2'b00;
      end
   end
   // Both enables reach the logic only through the base-clock chain
   logic tx_active;
   logic rx_active;
   assign tx_active = txe_sync_q[1];
   assign rx_active = rxe_sync_q[1];

   // Bit-period timer on base ticks
   logic [BAUD_DIV_W-1:0] bit_cnt_q;
   logic bit_tick;
   assign bit_tick = base_tick & (bit_cnt_q == 8'h00);
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bit_cnt_q <= 8'h00;
      end else if (run & ~tx_active) begin
         bit_cnt_q <= 8'h00;
      end else if (run & base_tick) begin
         bit_cnt_q <= (bit_cnt_q == 8'h00) ? (baud_div_q - 8'h01) : (bit_cnt_q - 8'h01);
      end
   end

   // Transmitter
   uep_tx_state_e tx_state_q;
   logic [3:0] frame_idx_q;
   logic [FRAME_BITS-1:0] frame_q;
   logic tx_pin_q;
   logic tx_done_pulse;
   assign tx_done_pulse = run & (tx_state_q == UEP_TX_DONE);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         tx_state_q <= UEP_TX_IDLE;
         frame_idx_q <= 4'h0;
         frame_q <= '1;
         tx_pin_q <= 1'b1;
      end else if (run) begin
         if (~tx_active) begin
            // Disabled transmitter returns to idle, line marks high
            tx_state_q <= UEP_TX_IDLE;
            frame_idx_q <= 4'h0;
            tx_pin_q <= 1'b1;
         end else begin
            case (tx_state_q)
               UEP_TX_IDLE: begin
                  if (tx_load_q & bit_tick) begin
                     frame_q <= {1'b1, tx_shift_reg_q, 1'b0};
                     frame_idx_q <= 4'h0;
                     tx_state_q <= UEP_TX_SHIFT;
                  end
               end
               UEP_TX_SHIFT: begin
                  if (bit_tick) begin
                     // Stop bit has stood a full bit period here
                     if (frame_idx_q == FRAME_BITS_CNT) begin
                        tx_state_q <= UEP_TX_DONE;
                     end else begin
                        tx_pin_q <= frame_q[frame_idx_q];
                        frame_idx_q <= frame_idx_q + 4'h1;
                     end
                  end
               end
               UEP_TX_DONE: begin
                  tx_state_q <= UEP_TX_IDLE;
               end
               default: begin
                  tx_state_q <= UEP_TX_IDLE;
               end
            endcase
         end
      end
   end
   assign serial_tx_pin_out = tx_pin_q;
   assign tx_done_irq_out = tx_done_pulse;

   // Pending load flag, consumed when the frame starts
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         tx_load_q <= 1'b0;
      end else if (run) begin
         if (wr_hit & (avs_address_in == {1'b0, OFS_TXDATA}) & tx_active) begin
            tx_load_q <= 1'b1;
         end else if ((tx_state_q == UEP_TX_IDLE) & tx_active & bit_tick) begin
            tx_load_q <= 1'b0;
         end else if (~tx_active) begin
            tx_load_q <= 1'b0;
         end
      end
   end

   // Busy covers a load still waiting for its first bit tick
   logic tx_busy;
   assign tx_busy = (tx_state_q != UEP_TX_IDLE) | tx_load_q;

   // Control and data registers
   // Ordering of power and enables is left to software
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         uart_power_on_q <= 1'b0;
         tx_enable_bit_q <= 1'b0;
         rx_enable_bit_q <= 1'b0;
         baud_sel_q <= BAUD_SEL_RST;
         baud_div_q <= BAUD_DIV_RST;
         tx_shift_reg_q <= '0;
      end else if (wr_hit) begin
         case (avs_address_in)
            {1'b0, OFS_CTRL}: begin
               if (avs_byteenable_in[0]) begin
                  uart_power_on_q <= avs_writedata_in[CTRL_POWER_BIT];
                  tx_enable_bit_q <= avs_writedata_in[CTRL_TXE_BIT];
                  rx_enable_bit_q <= avs_writedata_in[CTRL_RXE_BIT];
               end
            end
            {1'b0, OFS_BAUD}: begin
               if (avs_byteenable_in[0]) begin
                  baud_div_q <= avs_writedata_in[BAUD_DIV_W-1:0];
               end
               if (avs_byteenable_in[1]) begin
                  baud_sel_q <= avs_writedata_in[BAUD_SEL_SHIFT +: BAUD_SEL_W];
               end
            end
            {1'b0, OFS_TXDATA}: begin
               // Frame copies the word at its start; a later write feeds the next frame
               if (avs_byteenable_in[0]) begin
                  tx_shift_reg_q <= avs_writedata_in[DATA_BITS-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Interrupt status (set wins over clear) and enable
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_stat_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else if (run) begin
         if (tx_done_pulse) begin
            irq_stat_q <= 1'b1;
         end else if (wr_hit & (avs_address_in == OFS_IRQ_CLEAR) & avs_byteenable_in[0] &
                      avs_writedata_in[IRQ_TX_DONE_BIT]) begin
            irq_stat_q <= 1'b0;
         end
         if (wr_hit & (avs_address_in == OFS_IRQ_ENABLE) & avs_byteenable_in[0]) begin
            irq_en_q <= avs_writedata_in[IRQ_TX_DONE_BIT];
         end
      end
   end
   assign irq_out = irq_stat_q & irq_en_q;

   // Read data
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rdata_q <= '0;
      end else if (rd_hit) begin
         case (avs_address_in)
            {1'b0, OFS_CTRL}: begin
               rdata_q <= {29'h0, rx_enable_bit_q, tx_enable_bit_q, uart_power_on_q};
            end
            {1'b0, OFS_BAUD}: begin
               rdata_q <= {21'h0, baud_sel_q, baud_div_q};
            end
            {1'b0, OFS_TXDATA}: begin
               rdata_q <= {24'h0, tx_shift_reg_q};
            end
            {1'b0, OFS_STATUS}: begin
               rdata_q <= {28'h0, tx_pin_q, rx_active, tx_active, tx_busy};
            end
            OFS_IRQ_STATUS: begin
               rdata_q <= {31'h0, irq_stat_q};
            end
            // Clear register is write-only
            OFS_IRQ_CLEAR: begin
               rdata_q <= BUS_UNMAPPED;
            end
            OFS_IRQ_ENABLE: begin
               rdata_q <= {31'h0, irq_en_q};
            end
            default: begin
               rdata_q <= BUS_UNMAPPED;
            end
         endcase
      end
   end

endmodule // uep_uart_enable

// ===== logic/uep_pkg.sv
/*
 * Package for the serial enable/power sequencing block: register map,
 * field positions, reset values and baud timing counts.
 * Assumes a 10 MHz system clock and 32-bit Avalon-MM register access.
 */
package uep_pkg;
   localparam int unsigned SYS_CLK_HZ = 10000000;
   // Register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_BAUD = 4'h4;
   localparam logic [3:0] OFS_TXDATA = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hc;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h0 + 4'h0 + 4'h0 + 4'h0;
   // Second-page offsets (address bit 4 set)
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
   localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
   localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;
   localparam logic [4:0] OFS_CLKGATE = 5'h1c;
   // Control register fields
   localparam int CTRL_POWER_BIT = 0;
   localparam int CTRL_TXE_BIT = 1;
   localparam int CTRL_RXE_BIT = 2;
   // Status register fields
   localparam int STAT_TX_BUSY_BIT = 0;
   localparam int STAT_TXE_SYNC_BIT = 1;
   localparam int STAT_RXE_SYNC_BIT = 2;
   localparam int STAT_TX_PIN_BIT = 3;
   // Interrupt status fields
   localparam int IRQ_TX_DONE_BIT = 0;
   localparam int IRQ_WIDTH = 1;
   // Baud control: base clock divider select and bit-period count
   localparam int BAUD_SEL_W = 3;
   localparam int BAUD_DIV_W = 8;
   localparam logic [BAUD_SEL_W-1:0] BAUD_SEL_RST = 3'h0;
   localparam logic [BAUD_DIV_W-1:0] BAUD_DIV_RST = 8'h04;
   localparam int BAUD_SEL_SHIFT = 8;
   // Frame: start, 8 data, 1 stop
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = 10;
   localparam logic [3:0] FRAME_BITS_CNT = 4'ha;
   localparam logic [31:0] BUS_UNMAPPED = 32'h00000000;
endpackage

// ===== verification/uep_assertions.sv
/* Port checker for uep_uart_enable.
   Assumes one clock domain and the synchronous active-high reset. */
`timescale 1ns/1ns
module uep_assertions (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic clk_stop_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic serial_tx_pin_out,
   input wire logic tx_done_irq_out,
   input wire logic irq_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   logic req;
   assign req = avs_read_in | avs_write_in;
   AST_STOP_PIN: assert property (clk_stop_in |=> $stable(serial_tx_pin_out))
      else $error("tx pin moved during clock stop");
   AST_STOP_IRQ: assert property (clk_stop_in |=> $stable(irq_out) &&
      (!clk_stop_in || !tx_done_irq_out))
      else $error("interrupt moved during clock stop");
   AST_STOP_NOANS: assert property (clk_stop_in && req |-> avs_waitrequest_out)
      else $error("bus answered during clock stop");
   AST_FIRST_WAIT: assert property ($rose(req) |-> avs_waitrequest_out)
      else $error("no wait state on new request");
   AST_ONE_WAIT: assert property (req && avs_waitrequest_out && !clk_stop_in
      |=> !avs_waitrequest_out || clk_stop_in)
      else $error("more than one wait state");
   AST_DONE_PULSE: assert property (tx_done_irq_out && !clk_stop_in |=> !tx_done_irq_out)
      else $error("done pulse longer than one cycle");
   AST_DONE_LINE: assert property (tx_done_irq_out |-> serial_tx_pin_out)
      else $error("done while line not at stop level");
   AST_IRQ_CAUSE: assert property ($rose(irq_out)
      |-> tx_done_irq_out || $past(tx_done_irq_out) || $past(avs_write_in))
      else $error("interrupt rose without cause");
   AST_RESET_IDLE: assert property ($fell(rst_in) |-> serial_tx_pin_out && !irq_out)
      else $error("outputs not idle after reset");
   cover property (tx_done_irq_out);
   cover property (clk_stop_in && req);
   cover property (irq_out);
endmodule // uep_assertions
bind uep_uart_enable uep_assertions u_chk (.*);

// ===== verification/uep_rx_model.sv
/* Remote serial receiver: decodes 8N1 frames from the tx line.
   Assumes a fixed bit period in system clocks. */
`timescale 1ns/1ns
module uep_rx_model #(
   parameter int BIT = 8
) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic [7:0] byte_out,
   output int count_out
);
   initial begin
      byte_out = 8'h00;
      count_out = 0;
      forever begin
         @(negedge line_in);
         // Mid-bit sampling tolerates base-tick phase of the start edge
         repeat (BIT / 2) @(posedge clk_in);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk_in);
            byte_out[i] = line_in;
         end
         repeat (BIT) @(posedge clk_in);
         if (line_in === 1'b1) count_out++;
      end
   end
endmodule // uep_rx_model

// ===== verification/uart_enable_power_sequencing_tb.sv
/* Self-checking bench for uep_uart_enable with a receiver model.
   Assumes the 10 MHz clock and one wait state per bus access. */
`timescale 1ns/1ns
module uart_enable_power_sequencing_tb;
   import uep_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic clk_stop_in = 1'b0;
   logic [4:0] avs_address_in = 5'h00;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hf;
   logic [31:0] avs_readdata_out, q;
   logic avs_waitrequest_out, serial_tx_pin_out, tx_done_irq_out, irq_out, pin;
   logic [7:0] rx_byte, d;
   logic [7:0] seed = 8'h55;
   int rx_count, miscompares, checks_done, cyc;
   always #50 sys_clk_in = ~sys_clk_in;
   uep_uart_enable DUT (.*);
   uep_rx_model #(.BIT(8)) u_rx (.clk_in(sys_clk_in), .line_in(serial_tx_pin_out),
      .byte_out(rx_byte), .count_out(rx_count));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [31:0] ctrl(input logic p, input logic t, input logic r);
      return (32'(p) << CTRL_POWER_BIT) | (32'(t) << CTRL_TXE_BIT) | (32'(r) << CTRL_RXE_BIT);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Entered just after a rising edge; leaves one idle cycle between requests
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
      avs_read_in <= !w;
      avs_write_in <= w;
      avs_address_in <= a;
      avs_writedata_in <= wd;
      do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (tx_done_irq_out !== 1'b1 && n < 400) begin
         @(posedge sys_clk_in);
         n++;
      end
      chk(32'(n < 400), 32'h1);
   endtask
   // Enables need two base ticks before the transmitter sees them
   task automatic chk_sync();
      logic [31:0] e;
      e = (32'h1 << STAT_TX_PIN_BIT) | (32'h1 << STAT_TXE_SYNC_BIT) | (32'h1 << STAT_RXE_SYNC_BIT);
      repeat (4) @(posedge sys_clk_in);
      bus(1'b0, 5'(OFS_STATUS), 32'h0);
      chk(q, e);
   endtask
   task automatic summarize();
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      bus(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, OFS_CLKGATE, 32'h0);
      chk(q, BUS_UNMAPPED);
      bus(1'b1, 5'(OFS_BAUD), 32'h0104);
      bus(1'b1, 5'(OFS_TXDATA), 32'h5a);
      repeat (100) @(posedge sys_clk_in);
      chk(32'(rx_count), 32'h0);
      bus(1'b1, 5'(OFS_CTRL), ctrl(1'b1, 1'b0, 1'b0));
      bus(1'b1, 5'(OFS_CTRL), ctrl(1'b1, 1'b1, 1'b1));
      chk_sync();
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed;
         seed = lfsr(seed);
         if (i == 2) bus(1'b1, OFS_IRQ_ENABLE, 32'h1);
         bus(1'b1, 5'(OFS_TXDATA), {24'h0, d});
         wait_done();
         chk({24'h0, rx_byte}, {24'h0, d});
         @(posedge sys_clk_in);
         chk(32'(irq_out), 32'(i >= 2));
         bus(1'b0, OFS_IRQ_STATUS, 32'h0);
         chk(q, 32'h1);
         bus(1'b1, OFS_IRQ_CLEAR, 32'h1);
         chk(32'(irq_out), 32'h0);
         if (i == 3) begin
            bus(1'b1, 5'(OFS_CTRL), ctrl(1'b1, 1'b0, 1'b1));
            repeat (4) @(posedge sys_clk_in);
            bus(1'b1, 5'(OFS_CTRL), ctrl(1'b1, 1'b1, 1'b1));
            chk_sync();
         end
      end
      bus(1'b1, 5'(OFS_TXDATA), 32'hc3);
      repeat (30) @(posedge sys_clk_in);
      clk_stop_in <= 1'b1;
      @(posedge sys_clk_in);
      pin = serial_tx_pin_out;
      repeat (20) @(posedge sys_clk_in);
      chk(32'(serial_tx_pin_out), 32'(pin));
      clk_stop_in <= 1'b0;
      @(posedge sys_clk_in);
      bus(1'b0, 5'(OFS_BAUD), 32'h0);
      chk(q, 32'h00000104);
      bus(1'b1, 5'(OFS_CTRL), ctrl(1'b1, 1'b0, 1'b0));
      bus(1'b1, 5'(OFS_CTRL), ctrl(1'b0, 1'b0, 1'b0));
      repeat (100) @(posedge sys_clk_in);
      chk(32'(serial_tx_pin_out), 32'h1);
      summarize();
   end
endmodule // uart_enable_power_sequencing_tb
